// [core/pom_macrocells.sv]
// Eight configurable output macrocells with their product-term array,
// configured and observed over an AXI4-Lite slave.
// Assumes one 40 MHz clock; array pins are asynchronous and synchronised here.
//
// Contract
// - Registered cells use the shared clock pin and the shared enable pin.
// - Each cell is registered output or I/O cell, in any mix.
// - Registered output sums eight terms; I/O cell sums seven terms.
// - Pure input or combinatorial output is a restricted I/O cell.
// - Registers sample on the rising edge of the shared clock pin.
// - Simple mode: dedicated input or always enabled combinatorial output.
// - Simple mode: up to eight terms per output, polarity per output.
// - Simple mode: clock and enable pins are plain array inputs.
// - Simple mode: the centre two cells are outputs with no feedback.
// - Simple, direction zero: combinatorial output with feedback, not centre.
// - Simple, direction one: dedicated input, not centre cells.
// - Polarity zero gives active low output, one gives active high.
// - Sixty-four signature fuses, eight bytes, fuse numbers 2056 to 2119.
// - Two global bits set the mode; each cell has polarity and direction.
// - Reset drives every macrocell register low, well within 1 us.
//
// The AXI4-Lite slave port and the address map were decided locally.
`timescale 1ns/10ps
`include "pom_defines.svh"

module pom_macrocells (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] in_pins,
  input wire logic clk_pin,
  input wire logic oe_pin_n,
  input wire logic [7:0] cell_pin_i,
  output logic [7:0] cell_pin_o,
  output logic [7:0] cell_pin_oe
);

  // ****************************************************************************
  // Helpers
  // ****************************************************************************

  // Merge write data under byte strobes
  function automatic logic [31:0] pom_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                           input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction : pom_strb

  // One product term: every selected true and complement literal must hold
  function automatic logic pom_term(input pom_pkg::pom_lits_t tm, input pom_pkg::pom_lits_t cm,
                                    input pom_pkg::pom_lits_t v);
    return (&(~tm | v)) & (&(~cm | ~v));
  endfunction : pom_term

  // Term index of an address inside the term mask window; the window does not
  // start on a 512-byte boundary, so raw address bits would shift the index
  function automatic logic [5:0] pom_tidx(input logic [11:0] a);
    logic [11:0] o;
    o = a - `POM_OFS_TERM_BASE;
    return o[8:3];
  endfunction : pom_tidx

  // ****************************************************************************
  // Declarations
  // ****************************************************************************
  localparam int NT = `POM_CELLS * `POM_TERMS_PER_CELL;
  logic [2:0] ctrl_q, ctrl_d;
  logic [7:0] pol_q, pol_d;
  logic [7:0] dir_q, dir_d;
  logic [`POM_SIG_BITS-1:0] sig_q, sig_d;
  logic [NT-1:0] ptd_q, ptd_d;
  pom_pkg::pom_lits_t tmask_q [NT];
  pom_pkg::pom_lits_t tmask_d [NT];
  pom_pkg::pom_lits_t cmask_q [NT];
  pom_pkg::pom_lits_t cmask_d [NT];
  logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
  logic [11:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic [7:0] reg_q, reg_d;
  logic [7:0] pin_o_d, pin_oe_d;
  logic [10:0] sync1_q, sync2_q;
  logic [7:0] pin1_q, pin2_q;
  logic clk_prev_q;
  logic clk_rise;
  pom_pkg::pom_mode_t mode;

  // ****************************************************************************
  // Pin synchronisers
  // ****************************************************************************

  // Two stages before any array logic looks at a pin
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_q <= 11'h000;
      sync2_q <= 11'h000;
      pin1_q <= 8'h00;
      pin2_q <= 8'h00;
      clk_prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= {oe_pin_n, clk_pin, 1'b0, in_pins};
      sync2_q <= sync1_q;
      pin1_q <= cell_pin_i;
      pin2_q <= pin1_q;
      clk_prev_q <= sync2_q[9];
    end
  end

  assign clk_rise = sync2_q[9] & ~clk_prev_q;

  // mode from the two global bits
  assign mode = pom_pkg::pom_mode_t'({ctrl_q[`POM_CTRL_REG_SELECT], ctrl_q[`POM_CTRL_MODE_BIT]});

  // ****************************************************************************
  // AXI4-Lite slave and configuration registers
  // ****************************************************************************

  // Next state of the bus channels and the stored configuration
  always_comb
  begin
    logic do_write;
    logic [11:0] a;
    logic [31:0] d;
    logic ok;
    do_write = 1'b0;
    a = 12'h000;
    d = 32'h0000_0000;
    ok = 1'b0;
    ctrl_d = ctrl_q;
    pol_d = pol_q;
    dir_d = dir_q;
    sig_d = sig_q;
    ptd_d = ptd_q;
    tmask_d = tmask_q;
    cmask_d = cmask_q;
    aw_hold_d = aw_hold_q | (s_axi_awvalid & s_axi_awready);
    w_hold_d = w_hold_q | (s_axi_wvalid & s_axi_wready);
    awaddr_d = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_q;
    wdata_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_q;
    wstrb_d = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_q;
    bvalid_d = s_axi_bvalid & ~s_axi_bready;
    bresp_d = s_axi_bresp;
    do_write = aw_hold_d & w_hold_d & ~bvalid_d;
    a = awaddr_d;
    if (do_write)
    begin
      aw_hold_d = 1'b0;
      w_hold_d = 1'b0;
      bvalid_d = 1'b1;
      ok = 1'b1;
      if (a[11:2] == `POM_OFS_CTRL >> 2)
      begin
        d = pom_strb({29'h0000_0000, ctrl_q}, wdata_d, wstrb_d);
        ctrl_d = d[2:0];
      end
      else if (ctrl_q[`POM_CTRL_RUN])
      begin
        ok = 1'b0;
      end
      else if (a[11:2] == `POM_OFS_POLARITY >> 2)
      begin
        d = pom_strb({24'h00_0000, pol_q}, wdata_d, wstrb_d);
        pol_d = d[7:0];
      end
      else if (a[11:2] == `POM_OFS_DIRECTION >> 2)
      begin
        d = pom_strb({24'h00_0000, dir_q}, wdata_d, wstrb_d);
        dir_d = d[7:0];
      end
      else if (a[11:3] == `POM_OFS_SIG_LO >> 3)
      begin
        sig_d[a[2]*32 +: 32] = pom_strb(sig_q[a[2]*32 +: 32], wdata_d, wstrb_d);
      end
      else if (a[11:3] == `POM_OFS_PTD_LO >> 3)
      begin
        ptd_d[a[2]*32 +: 32] = pom_strb(ptd_q[a[2]*32 +: 32], wdata_d, wstrb_d);
      end
      else if (a >= `POM_OFS_TERM_BASE && a <= `POM_OFS_TERM_LAST)
      begin
        if (a[2])
        begin
          d = pom_strb({14'h0000, cmask_q[pom_tidx(a)]}, wdata_d, wstrb_d);
          cmask_d[pom_tidx(a)] = d[`POM_LITS-1:0];
        end
        else
        begin
          d = pom_strb({14'h0000, tmask_q[pom_tidx(a)]}, wdata_d, wstrb_d);
          tmask_d[pom_tidx(a)] = d[`POM_LITS-1:0];
        end
      end
      else
      begin
        ok = 1'b0;
      end
      bresp_d = ok ? pom_pkg::POM_RESP_OKAY : pom_pkg::POM_RESP_SLVERR;
    end
    awready_d = ~aw_hold_d & ~bvalid_d;
    wready_d = ~w_hold_d & ~bvalid_d;
    // Read channel: answer one cycle after the address is taken
    rvalid_d = s_axi_rvalid & ~s_axi_rready;
    rdata_d = s_axi_rdata;
    rresp_d = s_axi_rresp;
    if (s_axi_arvalid & s_axi_arready)
    begin
      a = s_axi_araddr;
      rvalid_d = 1'b1;
      rresp_d = pom_pkg::POM_RESP_OKAY;
      rdata_d = 32'h0000_0000;
      if (a[11:2] == `POM_OFS_CTRL >> 2)
      begin
        rdata_d = {29'h0000_0000, ctrl_q};
      end
      else if (a[11:2] == `POM_OFS_POLARITY >> 2)
      begin
        rdata_d = {24'h00_0000, pol_q};
      end
      else if (a[11:2] == `POM_OFS_DIRECTION >> 2)
      begin
        rdata_d = {24'h00_0000, dir_q};
      end
      else if (a[11:2] == `POM_OFS_STATUS >> 2)
      begin
        rdata_d = {16'h0000, cell_pin_oe, reg_q};
      end
      else if (a[11:3] == `POM_OFS_SIG_LO >> 3)
      begin
        rdata_d = sig_q[a[2]*32 +: 32];
      end
      else if (a[11:3] == `POM_OFS_PTD_LO >> 3)
      begin
        rdata_d = ptd_q[a[2]*32 +: 32];
      end
      else if (a >= `POM_OFS_TERM_BASE && a <= `POM_OFS_TERM_LAST)
      begin
        rdata_d = {14'h0000, a[2] ? cmask_q[pom_tidx(a)] : tmask_q[pom_tidx(a)]};
      end
      else
      begin
        rresp_d = pom_pkg::POM_RESP_SLVERR;
      end
    end
    arready_d = ~rvalid_d;
  end

  // Register the bus and configuration state
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q <= `POM_CTRL_RESET;
      pol_q <= `POM_POLARITY_RESET;
      dir_q <= `POM_DIRECTION_RESET;
      sig_q <= `POM_SIG_RESET;
      ptd_q <= `POM_PTD_RESET;
      for (int i = 0; i < NT; i++)
      begin
        tmask_q[i] <= '0;
        cmask_q[i] <= '0;
      end
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      pol_q <= pol_d;
      dir_q <= dir_d;
      sig_q <= sig_d;
      ptd_q <= ptd_d;
      tmask_q <= tmask_d;
      cmask_q <= cmask_d;
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rdata <= rdata_d;
      s_axi_rresp <= rresp_d;
    end
  end

  // ****************************************************************************
  // Macrocells and product-term array
  // ****************************************************************************

  // Next state of cell registers and pin drivers; outputs lag the array by one
  // clock so that every pin comes from a flop
  always_comb
  begin
    pom_pkg::pom_lits_t lits;
    logic [7:0] fb;
    logic [7:0] pt;
    logic sum8, sum7;
    logic centre;
    lits = '0;
    fb = 8'h00;
    pt = 8'h00;
    sum8 = 1'b0;
    sum7 = 1'b0;
    centre = 1'b0;
    reg_d = reg_q;
    pin_o_d = 8'h00;
    pin_oe_d = 8'h00;
    for (int c = 0; c < `POM_CELLS; c++)
    begin
      centre = (c == `POM_CENTRE_LO) || (c == `POM_CENTRE_HI);
      unique case (mode)
        // register feeds back from q, I/O cell from its pin
        pom_pkg::POM_MODE_REGISTERED: fb[c] = dir_q[c] ? pin2_q[c] : reg_q[c];
        pom_pkg::POM_MODE_SIMPLE: fb[c] = centre ? 1'b0 : pin2_q[c];
        pom_pkg::POM_MODE_COMPLEX: fb[c] = 1'b0;
        pom_pkg::POM_MODE_NONE: fb[c] = 1'b0;
      endcase
    end
    // clock and enable pins are array data only in simple mode
    lits = {fb, (mode == pom_pkg::POM_MODE_SIMPLE) ? sync2_q[10:9] : 2'b00, sync2_q[7:0]};
    for (int c = 0; c < `POM_CELLS; c++)
    begin
      centre = (c == `POM_CENTRE_LO) || (c == `POM_CENTRE_HI);
      for (int k = 0; k < `POM_TERMS_PER_CELL; k++)
      begin
        pt[k] = ~ptd_q[c*8+k] & pom_term(tmask_q[c*8+k], cmask_q[c*8+k], lits);
      end
      // eight terms for a register, seven plus enable term for I/O
      sum8 = |pt;
      sum7 = |pt[7:1];
      if (!ctrl_q[`POM_CTRL_RUN])
      begin
        reg_d[c] = 1'b0;
      end
      else
      begin
        unique case (mode)
          pom_pkg::POM_MODE_REGISTERED:
          begin
            if (!dir_q[c])
            begin
              // sample on the shared clock edge, inverted pin buffer
              if (clk_rise)
              begin
                reg_d[c] = pol_q[c] ? ~sum8 : sum8;
              end
              pin_o_d[c] = ~reg_d[c];
              pin_oe_d[c] = ~sync2_q[10];
            end
            else
            begin
              // enable term off gives a pure input
              reg_d[c] = 1'b0;
              pin_o_d[c] = pol_q[c] ? sum7 : ~sum7;
              pin_oe_d[c] = pt[0];
            end
          end
          pom_pkg::POM_MODE_SIMPLE:
          begin
            reg_d[c] = 1'b0;
            pin_o_d[c] = pol_q[c] ? sum8 : ~sum8;
            pin_oe_d[c] = centre | ~dir_q[c];
          end
          pom_pkg::POM_MODE_COMPLEX: reg_d[c] = 1'b0;
          pom_pkg::POM_MODE_NONE: reg_d[c] = 1'b0;
        endcase
      end
    end
  end

  // registers cleared on the first reset edge
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      reg_q <= 8'h00;
      cell_pin_o <= 8'h00;
      cell_pin_oe <= 8'h00;
    end
    else
    begin
      reg_q <= reg_d;
      cell_pin_o <= pin_o_d;
      cell_pin_oe <= pin_oe_d;
    end
  end

endmodule : pom_macrocells

// [core/pom_defines.svh]
// Constants of the output macrocell block: register offsets, field positions,
// reset values and signature fuse numbering.
// Assumes inclusion by bare name from the package and the top module.
`ifndef POM_DEFINES_SVH
`define POM_DEFINES_SVH

// ****************************************************************************
// Register offsets (byte addresses on the AXI4-Lite slave)
// ****************************************************************************
`define POM_OFS_CTRL 12'h000
`define POM_OFS_POLARITY 12'h004
`define POM_OFS_DIRECTION 12'h008
`define POM_OFS_STATUS 12'h00c
`define POM_OFS_SIG_LO 12'h010
`define POM_OFS_SIG_HI 12'h014
`define POM_OFS_PTD_LO 12'h018
`define POM_OFS_PTD_HI 12'h01c
`define POM_OFS_TERM_BASE 12'h100
`define POM_OFS_TERM_LAST 12'h2fc

// ****************************************************************************
// Field positions and reset values
// ****************************************************************************
`define POM_CTRL_RUN 0
`define POM_CTRL_REG_SELECT 1
`define POM_CTRL_MODE_BIT 2
`define POM_CTRL_RESET 3'h0
`define POM_POLARITY_RESET 8'h00
`define POM_DIRECTION_RESET 8'h00
`define POM_SIG_RESET 64'h0000_0000_0000_0000
`define POM_PTD_RESET 64'h0000_0000_0000_0000

// ****************************************************************************
// Array sizes and signature fuse numbering
// ****************************************************************************
`define POM_CELLS 8
`define POM_TERMS_PER_CELL 8
`define POM_LITS 18
`define POM_CENTRE_LO 3
`define POM_CENTRE_HI 4
`define POM_SIG_FUSE_FIRST 2056
`define POM_SIG_FUSE_LAST 2119
`define POM_SIG_BITS (`POM_SIG_FUSE_LAST - `POM_SIG_FUSE_FIRST + 1)

`endif

// [core/pom_pkg.sv]
// Types of the output macrocell block.
// Assumes the constants header is on the include path.
`include "pom_defines.svh"

package pom_pkg;

  // ****************************************************************************
  // Global mode, coded as {global_register_select, global_mode_bit}
  // ****************************************************************************
  typedef enum logic [1:0] {
    POM_MODE_NONE = 2'b00,
    POM_MODE_REGISTERED = 2'b01,
    POM_MODE_SIMPLE = 2'b10,
    POM_MODE_COMPLEX = 2'b11
  } pom_mode_t;

  // AXI response codes
  typedef enum logic [1:0] {
    POM_RESP_OKAY = 2'b00,
    POM_RESP_SLVERR = 2'b10
  } pom_resp_t;

  typedef logic [`POM_LITS-1:0] pom_lits_t;

endpackage : pom_pkg

// [tb/pom_macrocells_properties.sv]
// Port checker for the output macrocell block.
// Assumes one clock, aclk, and synchronous active-low aresetn.
`timescale 1ns/10ps

module pom_macrocells_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] cell_pin_o,
  input wire logic [7:0] cell_pin_oe
);
  // ****
  // Bus and pin properties
  // ****
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // Response one cycle after both halves are taken
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write response late");
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped");
  a_bvalid_ends: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid
    && s_axi_awready) else $error("write response not retired");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read data changed");
  a_rvalid_ends: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid
    && s_axi_arready) else $error("read not retired");
  // Only one transfer of each kind in flight
  a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during data");
  a_resp_code: assert property (s_axi_bvalid |-> s_axi_bresp == 2'h0
    || s_axi_bresp == 2'h2) else $error("bad write response code");
  a_reset_quiet: assert property ($rose(aresetn) |-> cell_pin_oe == 8'h00
    && cell_pin_o == 8'h00 && !s_axi_bvalid && !s_axi_rvalid && !s_axi_awready)
    else $error("outputs not cleared by reset");

  c_write: cover property (s_axi_bvalid && s_axi_bready);
  c_read_err: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'h2);
  c_pin_driven: cover property (cell_pin_oe == 8'h7f);
endmodule : pom_macrocells_properties

bind pom_macrocells pom_macrocells_properties u_props (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .cell_pin_o, .cell_pin_oe);

// [tb/tb_pom_macrocells.sv]
// Self-checking bench for the output macrocell block.
// Assumes the block alone, driven over AXI4-Lite and its pins at 40 MHz.
`timescale 1ns/10ps
`include "pom_defines.svh"

module tb_pom_macrocells;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [7:0] in_pins = 8'h00, cell_pin_i, cell_pin_o, cell_pin_oe;
  logic clk_pin = 1'b0, oe_pin_n = 1'b1;
  int error_cnt = 0, checks = 0, cyc = 0;

  pom_macrocells u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .in_pins, .clk_pin,
    .oe_pin_n, .cell_pin_i, .cell_pin_o, .cell_pin_oe);

  // 40 MHz clock
  always #12.5 aclk = ~aclk;

  // Watchdog, well above the few hundred cycles the tests use
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      error_cnt++;
      print_verdict();
    end
  end

  // Pins see their own drive, else the pull-up level
  always_comb cell_pin_i = (cell_pin_o & cell_pin_oe) | ~cell_pin_oe;

  // ****
  // Shared tasks
  // ****
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [31:0] m,
    input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    chk(s_axi_rdata & m, ed);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
    @(posedge aclk);
  endtask : rd

  // Let a pin change pass the synchronisers; read at the next edge what the
  // n-th edge left, so that later drives stay on clock edges
  task automatic waitc(input int n);
    repeat (n + 1) @(posedge aclk);
  endtask : waitc

  // ****
  // Scenarios
  // ****
  task automatic t_reset_vals();
    chk({16'h0, cell_pin_oe, cell_pin_o}, 32'h0);
    for (int i = 0; i < 8; i++)
      rd(12'(i * 4), 32'h0, 32'hffff_ffff, 2'h0);
  endtask : t_reset_vals

  task automatic t_regs();
    wr(`POM_OFS_SIG_LO, 32'h1234_5678, 2'h0);
    wr(`POM_OFS_SIG_HI, 32'h9abc_def0, 2'h0);
    rd(`POM_OFS_SIG_LO, 32'h1234_5678, 32'hffff_ffff, 2'h0);
    rd(`POM_OFS_SIG_HI, 32'h9abc_def0, 32'hffff_ffff, 2'h0);
    rd(12'h020, 32'h0, 32'hffff_ffff, 2'h2);
    wr(`POM_OFS_STATUS, 32'hffff, 2'h2);
    rd(`POM_OFS_STATUS, 32'h0, 32'hffff, 2'h0);
  endtask : t_regs

  // Cell 0 follows in_pins[0]; cell 2 is clk_pin or cell 0 fed back;
  // cell 3 is centre, cell 7 input
  task automatic t_simple();
    wr(`POM_OFS_POLARITY, 32'h05, 2'h0);
    wr(`POM_OFS_DIRECTION, 32'h88, 2'h0);
    wr(`POM_OFS_PTD_LO, 32'h00fc_00fe, 2'h0);
    wr(`POM_OFS_TERM_BASE, 32'h001, 2'h0);
    wr(`POM_OFS_TERM_BASE + 12'h080, 32'h100, 2'h0);
    wr(`POM_OFS_TERM_BASE + 12'h088, 32'h400, 2'h0);
    wr(`POM_OFS_CTRL, 32'h3, 2'h0);
    waitc(4);
    chk({24'h0, cell_pin_o & 8'h7f}, 32'h00);
    chk({24'h0, cell_pin_oe}, 32'h7f);
    in_pins <= 8'h01;
    waitc(6);
    chk({24'h0, cell_pin_o & 8'h7f}, 32'h05);
    in_pins <= 8'h00;
    clk_pin <= 1'b1;
    waitc(6);
    chk({24'h0, cell_pin_o & 8'h7f}, 32'h04);
    chk({24'h0, cell_pin_oe}, 32'h7f);
    wr(`POM_OFS_POLARITY, 32'hff, 2'h2);
    rd(`POM_OFS_POLARITY, 32'h05, 32'hffff_ffff, 2'h0);
    wr(`POM_OFS_CTRL, 32'h0, 2'h0);
    waitc(4);
    chk({24'h0, cell_pin_oe}, 32'h00);
  endtask : t_simple

  // Cell 0 registered, cell 1 I/O cell enabled by its first term
  task automatic t_registered();
    clk_pin <= 1'b0;
    oe_pin_n <= 1'b0;
    in_pins <= 8'h01;
    wr(`POM_OFS_POLARITY, 32'h00, 2'h0);
    wr(`POM_OFS_DIRECTION, 32'h02, 2'h0);
    wr(`POM_OFS_PTD_LO, 32'h0000_fefe, 2'h0);
    wr(`POM_OFS_CTRL, 32'h5, 2'h0);
    waitc(4);
    chk({31'h0, cell_pin_o[0]}, 32'h1);
    chk({24'h0, cell_pin_oe & 8'h03}, 32'h03);
    clk_pin <= 1'b1;
    waitc(2);
    chk({31'h0, cell_pin_o[0]}, 32'h1);
    waitc(1);
    chk({31'h0, cell_pin_o[0]}, 32'h0);
    rd(`POM_OFS_STATUS, 32'h1, 32'h1, 2'h0);
    oe_pin_n <= 1'b1;
    waitc(3);
    chk({24'h0, cell_pin_oe & 8'h03}, 32'h02);
    for (int i = 0; i < 2; i++)
    begin
      wr(`POM_OFS_CTRL, i ? 32'h1 : 32'h7, 2'h0);
      waitc(4);
      chk({24'h0, cell_pin_oe}, 32'h00);
    end
    wr(`POM_OFS_CTRL, 32'h0, 2'h0);
    rd(`POM_OFS_STATUS, 32'h0, 32'hff, 2'h0);
  endtask : t_registered

  // Reset in mid-run must clear a cell register that holds a one
  task automatic t_reset_again();
    wr(`POM_OFS_CTRL, 32'h5, 2'h0);
    clk_pin <= 1'b0;
    waitc(3);
    clk_pin <= 1'b1;
    waitc(4);
    rd(`POM_OFS_STATUS, 32'h1, 32'h1, 2'h0);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk({16'h0, cell_pin_oe, cell_pin_o}, 32'h0);
    rd(`POM_OFS_STATUS, 32'h0, 32'hffff, 2'h0);
  endtask : t_reset_again

  task automatic print_verdict();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence after a three-cycle reset
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_reset_vals();
    t_regs();
    t_simple();
    t_registered();
    t_reset_again();
    print_verdict();
  end
endmodule : tb_pom_macrocells
